// [core/io_write_trap_nmi_capture.sv]
// Host I/O write trap unit with status, capture queue and adapter state
`timescale 1ns/1ps
module io_write_trap_nmi_capture
   import trap_pkg::*;
#(
   parameter int DEPTH = 4
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       srst,
   // Extension register port (index 3C5 style)
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_index,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   // Decoded host write events
   input  wire logic       ev_valid,
   input  wire logic       ev_is_index,
   input  wire logic [7:0] ev_one,
   input  wire logic [7:0] ev_two,
   input  wire logic [7:0] ev_addr,
   input  wire logic [7:0] ev_data,
   input  wire logic [5:0] ev_index,
   // Automatic mode switch request
   input  wire logic       sw_req,
   input  wire logic [1:0] sw_mode,
   // Outputs
   output logic            nmi,
   output logic            legacy_timing,
   output logic            legacy_cursor,
   output logic            legacy_port_rd,
   output logic            native_port_wr,
   output logic            vga_ext_en
);
   // =======================================================
   // Registers
   logic [7:0]  trap_mask_one_r, trap_mask_two_r;
   logic [7:0]  trap_status_one_r, trap_status_two_r;
   logic [7:0]  host_read_window_index_r;
   logic [7:0]  software_scratch_bank_r [16];
   logic        changed_r;
   logic [2:0]  prev_r, cur_r;
   logic [23:0] rec_r [DEPTH];
   logic [1:0]  wp_r, rp_r;
   logic [2:0]  cnt_r;
   logic        ovr_r;
   phase_t      ph_r;

   // =======================================================
   // Event qualification
   logic [7:0] hit_one, hit_two;
   logic       trap, do_switch, rd_stat1, rd_stat2, rd_cap, rd_state;
   logic       pop, push, full, empty;
   logic [7:0] addr_byte, cap_byte;

   assign do_switch = sw_req && (sw_mode != cur_r[1:0]);
   // Index writes are never events
   always_comb begin
      hit_one = '0;
      hit_two = '0;
      if (ev_valid && !ev_is_index) begin
         hit_one = ev_one & trap_mask_one_r;
         hit_two = ev_two & trap_mask_two_r;
      end
      hit_one[S1_STATE_CHANGE] = do_switch &&
                                 trap_mask_one_r[S1_STATE_CHANGE];
   end
   assign trap = (|hit_one) || (|hit_two);

   assign rd_stat1 = reg_rd && reg_index == IDX_STAT_ONE;
   assign rd_stat2 = reg_rd && reg_index == IDX_STAT_TWO;
   assign rd_cap   = reg_rd && reg_index == IDX_CAPTURE;
   assign rd_state = reg_rd && reg_index == IDX_STATE;
   assign full  = cnt_r == 3'(DEPTH);
   assign empty = cnt_r == 3'h0;
   assign pop   = rd_cap && !empty && ph_r == PH_FLAGS;
   assign push  = trap && !full;

   // =======================================================
   // Mask and window registers
   always_ff @(posedge clk) begin
      if (srst) begin
         trap_mask_one_r          <= MASK_RESET;
         trap_mask_two_r          <= MASK_RESET;
         host_read_window_index_r <= READ_WIN_RESET;
      end else if (reg_wr) begin
         if (reg_index == IDX_MASK_ONE)
            trap_mask_one_r <= reg_wdata;
         if (reg_index == IDX_MASK_TWO)
            trap_mask_two_r <= reg_wdata;
         if (reg_index == IDX_READ_WIN)
            host_read_window_index_r <= reg_wdata;
      end
   end

   // Scratch has no reset by design
   always_ff @(posedge clk) begin
      if (reg_wr && reg_index[7:4] == IDX_SCRATCH_HI)
         software_scratch_bank_r[reg_index[3:0]] <= reg_wdata;
   end

   // =======================================================
   // Status registers; a new event wins over read-clear
   always_ff @(posedge clk) begin
      if (srst) begin
         trap_status_one_r <= STAT_RESET;
         trap_status_two_r <= STAT_RESET;
      end else begin
         trap_status_one_r <= (rd_stat1 ? 8'h00 : trap_status_one_r)
                              | hit_one;
         trap_status_two_r <= (rd_stat2 ? 8'h00 : trap_status_two_r)
                              | hit_two;
      end
   end

   // NMI follows any pending enabled status
   always_ff @(posedge clk) begin
      if (srst)
         nmi <= 1'b0;
      else
         nmi <= trap || (|((rd_stat1 ? 8'h00 : trap_status_one_r)))
                      || (|((rd_stat2 ? 8'h00 : trap_status_two_r)));
   end

   // =======================================================
   // Capture queue
   always_comb begin
      addr_byte = {1'b1, ev_addr[7:4] == NIB_D, ev_addr[7:4] == NIB_C,
                   ev_addr[7:4] == NIB_B, ev_addr[3:0]};
   end

   always_ff @(posedge clk) begin
      if (push)
         rec_r[wp_r] <= {ev_data, addr_byte, 2'b00, ev_index};
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         wp_r  <= 2'h0;
         rp_r  <= 2'h0;
         cnt_r <= 3'h0;
         ovr_r <= 1'b0;
         ph_r  <= PH_DATA;
      end else begin
         if (push)
            wp_r <= wp_r + 2'h1;
         if (pop)
            rp_r <= rp_r + 2'h1;
         cnt_r <= cnt_r + 3'(push) - 3'(pop);
         // Overrun stays until the flags byte reports it
         if (trap && full)
            ovr_r <= 1'b1;
         else if (pop)
            ovr_r <= 1'b0;
         if (rd_cap && !empty) begin
            unique case (ph_r)
               PH_DATA:  ph_r <= PH_ADDR;
               PH_ADDR:  ph_r <= PH_FLAGS;
               PH_FLAGS: ph_r <= PH_DATA;
               default:  ph_r <= PH_DATA;
            endcase
         end
      end
   end

   always_comb begin
      cap_byte = 8'h00;
      if (!empty) begin
         unique case (ph_r)
            PH_DATA:  cap_byte = rec_r[rp_r][23:16];
            PH_ADDR:  cap_byte = rec_r[rp_r][15:8];
            PH_FLAGS: begin
               cap_byte = rec_r[rp_r][7:0];
               cap_byte[REC_EMPTY]   = cnt_r == 3'h1;
               cap_byte[REC_OVERRUN] = ovr_r;
            end
            default:  cap_byte = 8'h00;
         endcase
      end
   end
   // Queue emptiness does not follow status: status reads never pop the queue
   // and capture reads never clear status bits, so either can empty first

   // =======================================================
   // Adapter state
   always_ff @(posedge clk) begin
      if (srst) begin
         changed_r <= 1'b0;
         prev_r    <= STATE_RESET;
         cur_r     <= STATE_RESET;
      end else begin
         if (do_switch) begin
            prev_r    <= cur_r;
            cur_r     <= {cur_r[ST_VGA], sw_mode};
            changed_r <= 1'b1;
         end else begin
            if (rd_state)
               changed_r <= 1'b0;
            if (reg_wr && reg_index == IDX_STATE) begin
               prev_r <= reg_wdata[6:4];
               cur_r  <= reg_wdata[2:0];
            end
         end
      end
   end

   // =======================================================
   // Mode steering and read data
   always_ff @(posedge clk) begin
      if (srst) begin
         legacy_timing  <= 1'b0;
         legacy_cursor  <= 1'b0;
         legacy_port_rd <= 1'b0;
         native_port_wr <= 1'b1;
         vga_ext_en     <= 1'b0;
      end else begin
         legacy_timing  <= cur_r[1:0] == MODE_CGA ||
                           cur_r[1:0] == MODE_MGA;
         legacy_cursor  <= cur_r[1:0] != MODE_EGA;
         legacy_port_rd <= cur_r[1:0] != MODE_EGA;
         native_port_wr <= cur_r[1:0] == MODE_EGA;
         vga_ext_en     <= cur_r[ST_VGA];
      end
   end

   always_ff @(posedge clk) begin
      if (srst)
         reg_rdata <= 8'h00;
      else if (reg_rd) begin
         if (reg_index[7:4] == IDX_SCRATCH_HI)
            reg_rdata <= software_scratch_bank_r[reg_index[3:0]];
         else
            unique case (reg_index)
               IDX_MASK_ONE: reg_rdata <= trap_mask_one_r;
               IDX_MASK_TWO: reg_rdata <= trap_mask_two_r;
               IDX_STAT_ONE: reg_rdata <= trap_status_one_r;
               IDX_STAT_TWO: reg_rdata <= trap_status_two_r;
               IDX_CAPTURE:  reg_rdata <= cap_byte;
               IDX_STATE:    reg_rdata <= {changed_r, prev_r, 1'b0, cur_r};
               IDX_READ_WIN: reg_rdata <= host_read_window_index_r;
               default:      reg_rdata <= 8'h00;
            endcase
      end
   end
endmodule // io_write_trap_nmi_capture

// [core/trap_pkg.sv]
// Package of register indices, field positions and reset values for the trap unit
package trap_pkg;
   // =======================================================
   // Extension register indices
   localparam logic [7:0] IDX_MASK_ONE   = 8'ha8;
   localparam logic [7:0] IDX_MASK_TWO   = 8'ha9;
   localparam logic [7:0] IDX_STAT_ONE   = 8'hab;
   localparam logic [7:0] IDX_STAT_TWO   = 8'hac;
   localparam logic [7:0] IDX_CAPTURE    = 8'hae;
   localparam logic [7:0] IDX_STATE      = 8'haf;
   localparam logic [7:0] IDX_SCRATCH    = 8'hb0;
   localparam logic [3:0] IDX_SCRATCH_HI = 4'hb;
   localparam logic [7:0] IDX_READ_WIN   = 8'hc0;
   // =======================================================
   // Reset values
   localparam logic [7:0] MASK_RESET     = 8'h00;
   localparam logic [7:0] STAT_RESET     = 8'h00;
   localparam logic [7:0] READ_WIN_RESET = 8'h00;
   localparam logic [2:0] STATE_RESET    = 3'h0;
   // =======================================================
   // Status one bit positions
   localparam int S1_MONO_IN_COLOR = 7;
   localparam int S1_COLOR_IN_MONO = 6;
   localparam int S1_STATE_CHANGE  = 5;
   // =======================================================
   // Capture record fields
   localparam int      CAP_DEPTH     = 4;
   localparam int      REC_WRITE     = 7;
   localparam int      REC_NIB_D     = 6;
   localparam int      REC_NIB_C     = 5;
   localparam int      REC_NIB_B     = 4;
   localparam int      REC_EMPTY     = 7;
   localparam int      REC_OVERRUN   = 6;
   localparam logic [3:0] NIB_D      = 4'hd;
   localparam logic [3:0] NIB_C      = 4'hc;
   localparam logic [3:0] NIB_B      = 4'hb;
   // =======================================================
   // Adapter state field positions
   localparam int ST_CHANGED = 7;
   localparam int ST_PREV_LO = 4;
   localparam int ST_VGA     = 2;
   // Basic modes, bit 2 excluded
   localparam logic [1:0] MODE_CGA = 2'b01;
   localparam logic [1:0] MODE_MGA = 2'b10;
   localparam logic [1:0] MODE_EGA = 2'b00;
   localparam logic [1:0] MODE_TXT = 2'b11;
   // Byte pointer phases inside a record
   typedef enum logic [2:0] {
      PH_DATA  = 3'b001,
      PH_ADDR  = 3'b010,
      PH_FLAGS = 3'b100
   } phase_t;
endpackage

// [dv/io_write_trap_nmi_capture_monitor.sv]
// Port checker for the I/O write trap unit
`timescale 1ns/1ps
// ======
module io_write_trap_nmi_capture_monitor
   import trap_pkg::*;
(
   // Clock and requests
   input wire logic       clk,
   input wire logic       srst,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_index,
   input wire logic       ev_valid,
   input wire logic       ev_is_index,
   input wire logic       sw_req,
   input wire logic [1:0] sw_mode,
   // Design outputs
   input wire logic [7:0] reg_rdata,
   input wire logic       nmi,
   input wire logic       legacy_cursor,
   input wire logic       legacy_port_rd,
   input wire logic       native_port_wr,
   input wire logic       vga_ext_en
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   // Status read with no event racing it
   logic st1;
   assign st1 = reg_rd && reg_index == IDX_STAT_ONE && !ev_valid && !sw_req;
   a_index_no_nmi: assert property (
      !nmi && !sw_req && (!ev_valid || ev_is_index) |=> !nmi)
      else $error("nmi rose with no trap event");
   a_nmi_fall_read: assert property (
      $fell(nmi) |-> $past(reg_rd) || $past(reg_rd, 2))
      else $error("nmi fell with no register read");
   a_stat_reread_zero: assert property (
      st1 ##1 st1 |=> reg_rdata == 8'h00)
      else $error("status not cleared by read");
   a_rdata_holds: assert property (
      !reg_rd |=> $stable(reg_rdata))
      else $error("read data moved without read");
   a_cursor_port_pair: assert property (
      legacy_cursor == legacy_port_rd)
      else $error("cursor and port read owners differ");
   a_native_excl: assert property (
      native_port_wr != legacy_cursor)
      else $error("native write and legacy cursor clash");
   a_ega_switch: assert property (
      sw_req && sw_mode == MODE_EGA && !reg_wr |-> ##2
      native_port_wr && !legacy_cursor)
      else $error("switch to native mode not applied");
   a_bit2_kept: assert property (
      (!reg_wr)[*3] ##0 sw_req |=> $stable(vga_ext_en)[*2])
      else $error("auto switch changed extension bit");
endmodule // io_write_trap_nmi_capture_monitor
bind io_write_trap_nmi_capture io_write_trap_nmi_capture_monitor i_mon (
   .clk, .srst, .reg_wr, .reg_rd, .reg_index, .ev_valid, .ev_is_index,
   .sw_req, .sw_mode, .reg_rdata, .nmi, .legacy_cursor, .legacy_port_rd,
   .native_port_wr, .vga_ext_en);

// [dv/host_io_model.sv]
// Host bus model issuing decoded I/O write cycles
`timescale 1ns/1ps
// ======
module host_io_model (
   // Clock
   input  wire logic       clk,
   // Decoded write cycle
   output logic            ev_valid,
   output logic            ev_is_index,
   output logic      [7:0] ev_one,
   output logic      [7:0] ev_two,
   output logic      [7:0] ev_addr,
   output logic      [7:0] ev_data,
   output logic      [5:0] ev_index
);
   initial {ev_valid, ev_is_index, ev_one, ev_two, ev_addr, ev_data} = '0;
   initial ev_index = '0;
   task automatic io_wr(input logic x, input logic [7:0] o, t, a, dt,
                        input logic [5:0] ix);
      @(posedge clk);
      {ev_valid, ev_is_index, ev_one, ev_two} <= {1'b1, x, o, t};
      {ev_addr, ev_data, ev_index} <= {a, dt, ix};
   endtask
   // Released bus shows no stale value
   task automatic io_idle;
      @(posedge clk);
      {ev_valid, ev_is_index, ev_one, ev_two} <= '0;
      {ev_addr, ev_data, ev_index} <= ~{ev_addr, ev_data, ev_index};
   endtask
endmodule // host_io_model

// [dv/io_write_trap_nmi_capture_tb.sv]
// Self-checking bench for the I/O write trap unit
`timescale 1ns/1ps
// ======
module io_write_trap_nmi_capture_tb;
   import trap_pkg::*;
   logic       clk, srst, reg_wr, reg_rd, sw_req, nmi, ev_valid;
   logic       rd_d = 1'b0;
   logic       ev_is_index, legacy_timing, legacy_cursor, legacy_port_rd;
   logic       native_port_wr, vga_ext_en;
   logic [1:0] sw_mode, m [4] = '{2'b01, 2'b10, 2'b11, 2'b00};
   logic [2:0] cur, prev;
   logic [3:0] nib [5] = '{4'hd, 4'hc, 4'hb, 4'h3, 4'hd};
   logic [5:0] ev_index, ix [5];
   logic [7:0] reg_index, reg_wdata, reg_rdata, ev_one, ev_two, ev_addr;
   logic [7:0] ev_data, v, d [5], exp_q [$];
   logic [7:0] ri [6] = '{IDX_MASK_ONE, IDX_MASK_TWO, IDX_STAT_ONE,
                          IDX_STAT_TWO, IDX_STATE, IDX_READ_WIN};
   int         error_cnt, compares;
   io_write_trap_nmi_capture #(.DEPTH(CAP_DEPTH)) i_io_write_trap_nmi_capture (
      .clk, .srst, .reg_wr, .reg_rd, .reg_index, .reg_wdata, .reg_rdata,
      .ev_valid, .ev_is_index, .ev_one, .ev_two, .ev_addr, .ev_data,
      .ev_index, .sw_req, .sw_mode, .nmi, .legacy_timing, .legacy_cursor,
      .legacy_port_rd, .native_port_wr, .vga_ext_en);
   host_io_model i_host_io_model (.clk, .ev_valid, .ev_is_index, .ev_one,
      .ev_two, .ev_addr, .ev_data, .ev_index);
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic check(input string n, input logic [7:0] seen, e);
      compares++;
      if (seen !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", n, e, seen);
      end
   endtask
   task automatic stop_test;
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic wr(input logic [7:0] i, x);
      @(posedge clk);
      {reg_wr, reg_index, reg_wdata} <= {1'b1, i, x};
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   // Hold keeps the strobe up for back-to-back reads
   task automatic rd(input logic [7:0] i, e, input bit hold = 0);
      @(posedge clk);
      {reg_rd, reg_index} <= {1'b1, i};
      exp_q.push_back(e);
      if (!hold) begin
         @(posedge clk);
         reg_rd <= 1'b0;
      end
   endtask
   task automatic sw(input logic [1:0] md);
      @(posedge clk);
      {sw_req, sw_mode} <= {1'b1, md};
      @(posedge clk);
      sw_req <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   task automatic modes(input logic [2:0] s);
      check("timing", legacy_timing, s[1] ^ s[0]);
      check("cursor", legacy_cursor, |s[1:0]);
      check("port_rd", legacy_port_rd, |s[1:0]);
      check("port_wr", native_port_wr, ~|s[1:0]);
      check("vga_ext", vga_ext_en, s[2]);
   endtask
   // Read results arrive one cycle after the strobe
   always @(posedge clk) begin
      if (rd_d) check("rdata", reg_rdata, exp_q.pop_front());
      rd_d <= reg_rd;
   end
   initial begin
      repeat (5000) @(posedge clk);
      error_cnt++;
      stop_test();
   end
   initial begin
      // Reset high, every strobe low
      {srst, reg_wr, reg_rd, sw_req, sw_mode} = 6'h20;
      {reg_index, reg_wdata} = '0;
      void'($urandom(32'hef87eeaa));
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      modes(3'b000);
      check("nmi", nmi, 0);
      for (int k = 0; k < 6; k++) rd(ri[k], 8'h00, k < 5);
      for (int k = 0; k < 17; k++) begin
         v = 8'($urandom);
         wr(k < 16 ? IDX_SCRATCH + 8'(k) : IDX_READ_WIN, v);
         rd(k < 16 ? IDX_SCRATCH + 8'(k) : IDX_READ_WIN, v);
      end
      wr(IDX_MASK_ONE, 8'h21);
      wr(IDX_MASK_TWO, 8'h80);
      rd(IDX_MASK_ONE, 8'h21, 1);
      rd(IDX_MASK_TWO, 8'h80);
      i_host_io_model.io_wr(1'b0, 8'h02, 8'h00, 8'hb9, 8'h5a, 6'h01);
      i_host_io_model.io_wr(1'b1, 8'h01, 8'h80, 8'hd4, 8'h11, 6'h02);
      i_host_io_model.io_idle();
      repeat (2) @(posedge clk);
      check("nmi", nmi, 0);
      rd(IDX_STAT_ONE, 8'h00);
      // Five writes back to back: the last finds the queue full
      for (int k = 0; k < 5; k++) begin
         d[k] = 8'($urandom);
         ix[k] = 6'($urandom);
         i_host_io_model.io_wr(1'b0, k[0] ? 8'h00 : 8'h01,
            k[0] ? 8'h80 : 8'h00, {nib[k], 4'(k)}, d[k], ix[k]);
      end
      i_host_io_model.io_idle();
      check("nmi", nmi, 1);
      for (int k = 0; k < 4; k++) begin
         rd(IDX_CAPTURE, d[k], 1);
         rd(IDX_CAPTURE, {1'b1, nib[k] == NIB_D, nib[k] == NIB_C,
            nib[k] == NIB_B, 4'(k)}, 1);
         rd(IDX_CAPTURE, {k == 3, k == 0, ix[k]}, 1);
      end
      rd(IDX_STAT_ONE, 8'h01, 1);
      rd(IDX_STAT_ONE, 8'h00, 1);
      rd(IDX_STAT_TWO, 8'h80, 1);
      rd(IDX_STAT_TWO, 8'h00, 1);
      rd(IDX_CAPTURE, 8'h00);
      repeat (2) @(posedge clk);
      check("nmi", nmi, 0);
      wr(IDX_STATE, 8'h03);
      repeat (2) @(posedge clk);
      modes(3'b011);
      wr(IDX_STATE, 8'h04);
      repeat (2) @(posedge clk);
      modes(3'b100);
      cur = 3'b100;
      for (int k = 0; k < 4; k++) begin
         prev = cur;
         sw(m[k]);
         cur = {1'b1, m[k]};
         modes(cur);
         rd(IDX_STATE, {1'b1, prev, 1'b0, cur});
      end
      rd(IDX_STATE, {1'b0, prev, 1'b0, cur}, 1);
      rd(IDX_STAT_ONE, 8'h20);
      repeat (2) @(posedge clk);
      stop_test();
   end
endmodule // io_write_trap_nmi_capture_tb
